//--- include/sram_port_pkg.sv
`default_nettype none
package sram_port_pkg;
  // Link geometry
  localparam int ADDR_W     = 20;
  localparam int DATA_W     = 36;
  localparam int LANES      = 4;
  // Stored depth of the flop array, in address bits
  localparam int ARRAY_AW   = 6;
  // Depth of the write-record buffer
  localparam int FIFO_DEPTH = 16;
  // Highest clock rate for the bypass latency mode
  localparam int BYPASS_MAX_MHZ = 167;
  // Values after reset
  localparam logic RST_FLAG  = 1'b0;
  localparam logic RST_IDLE_N = 1'b1;
endpackage
`default_nettype wire

//--- verilog/sram_port.sv
`default_nettype none
// Buffer of records with valid and ready on both sides
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshake terms and honest full and empty
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = store[rd_ptr];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Behaviour
// - A true-clock edge starts each access; array work then runs without strobes.
// - Read and write commands are accepted in any order on true-clock edges.
// - True-clock edge captures address, controls, lane enables and first write beat.
// - Complement-clock edge captures second-beat lane enables and write data.
// - Every access moves exactly two beats, one per clock phase.
// - Lane enables travel with each beat and mask lanes independently.
// - Late write: first data beat arrives one cycle after the write command.
// - With delay loop on, first read beat leaves 2.5 cycles after command.
// - With delay loop on, second read beat leaves on the fourth true-clock edge counting the command.
// - Echo clocks toggle together with the launched read data.
// - All link inputs and read outputs pass through boundary registers.
// - Strobe low: direction high reads, low writes; strobe high starts nothing.
// - Data pins are released whenever no read beat is being driven.
// - Delay-loop disable low selects 1.0-cycle read latency, below 167 MHz.
// - Read-valid flag marks the beats carrying read data, aligned with echoes.
module sram_port #(
  parameter int ADDR_W   = sram_port_pkg::ADDR_W,
  parameter int DATA_W   = sram_port_pkg::DATA_W,
  parameter int LANES    = sram_port_pkg::LANES,
  parameter int ARRAY_AW = sram_port_pkg::ARRAY_AW,
  parameter int DEPTH    = sram_port_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Link clocks
  input  wire logic                k_clk,
  input  wire logic                k_clk_n,
  // Link command pins
  input  wire logic                load_strobe_n,
  input  wire logic                rw_sel,
  input  wire logic [ADDR_W-1:0]   word_address,
  input  wire logic [LANES-1:0]    lane_write_en_n,
  input  wire logic                dll_off_n,
  // Shared data pins
  input  wire logic [DATA_W-1:0]   dq_i,
  output logic [DATA_W-1:0]        dq_o,
  output logic                     dq_oe,
  // Echo and valid outputs
  output logic                     echo_strobe_pos,
  output logic                     echo_strobe_neg,
  output logic                     read_valid_flag,
  // Record of each committed write that finds the record handshake idle
  output logic                     wlog_valid,
  input  wire logic                wlog_ready,
  output logic [ADDR_W-1:0]        wlog_addr,
  output logic [2*DATA_W-1:0]      wlog_data,
  output logic [2*LANES-1:0]       wlog_lanes
);
  import sram_port_pkg::*;
  localparam int LANE_W = DATA_W / LANES;
  localparam int REC_W  = ADDR_W + 2*DATA_W + 2*LANES;

  logic [1:0]          k_rst_sync;
  logic [1:0]          dll_sync;
  logic                k_rst;
  logic                dll_on;
  logic                r_load_n;
  logic                r_rw;
  logic [ADDR_W-1:0]   r_addr;
  logic [DATA_W-1:0]   r_d0;
  logic [DATA_W-1:0]   r_d1;
  logic [LANES-1:0]    r_be0;
  logic [LANES-1:0]    r_be1;
  logic                cmd_rd;
  logic                cmd_wr;
  logic                w1;
  logic [ADDR_W-1:0]   w_addr;
  logic                s1;
  logic [ADDR_W-1:0]   s1_addr;
  logic [DATA_W-1:0]   mem0 [2**ARRAY_AW];
  logic [DATA_W-1:0]   mem1 [2**ARRAY_AW];
  logic                fv_now;
  logic [ADDR_W-1:0]   fa;
  logic                hit;
  logic [DATA_W-1:0]   fd0;
  logic [DATA_W-1:0]   fd1;
  logic                f_v;
  logic [DATA_W-1:0]   f_d0;
  logic [DATA_W-1:0]   f_d1;
  logic                bk;
  logic [DATA_W-1:0]   q_k;
  logic [DATA_W-1:0]   q_kn;
  logic                oe_k;
  logic                oe_kn;
  logic                ep_k;
  logic                ep_kn;
  logic                en_k;
  logic                en_kn;
  logic                x_req;
  logic [1:0]          ack_s;
  logic [REC_W-1:0]    rec;
  logic [1:0]          req_s;
  logic                x_ack;
  logic                f_in_valid;
  logic                f_in_ready;
  logic                f_out_valid;
  logic                f_out_ready;
  logic [REC_W-1:0]    f_out_data;

  // Array index from a link address
  function automatic logic [ARRAY_AW-1:0] idx(input logic [ADDR_W-1:0] a);
    idx = a[ARRAY_AW-1:0];
  endfunction

  // Replace only the enabled lanes of a word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [LANES-1:0]  be);
    merge = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (be[i]) begin
        merge[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
  endfunction

  // Reset and latency-mode pins brought into the link domain
  always_ff @(posedge k_clk) begin
    k_rst_sync <= {k_rst_sync[0], srst};
    dll_sync   <= {dll_sync[0], dll_off_n};
  end
  assign k_rst  = k_rst_sync[1];
  assign dll_on = dll_sync[1];

  // True-clock boundary registers
  always_ff @(posedge k_clk) begin
    r_load_n <= k_rst ? RST_IDLE_N : load_strobe_n;
    r_rw   <= rw_sel;
    r_addr <= word_address;
    r_d0   <= dq_i;
    r_be0  <= ~lane_write_en_n;
  end

  // Complement-clock boundary registers for the second beat
  always_ff @(posedge k_clk_n) begin
    r_d1  <= dq_i;
    r_be1 <= ~lane_write_en_n;
  end

  // Command decode; any order of reads and writes is accepted
  assign cmd_rd = !r_load_n && r_rw;
  assign cmd_wr = !r_load_n && !r_rw;

  // Write buffer holds the address until the data beats arrive
  always_ff @(posedge k_clk) begin
    w1     <= k_rst ? RST_FLAG : cmd_wr;
    w_addr <= r_addr;
  end

  // Self-timed commit of both beats with per-lane masking
  always_ff @(posedge k_clk) begin
    if (w1) begin
      mem0[idx(w_addr)] <= merge(mem0[idx(w_addr)], r_d0, r_be0);
      mem1[idx(w_addr)] <= merge(mem1[idx(w_addr)], r_d1, r_be1);
    end
  end

  // Read address stage used in delay-loop mode
  always_ff @(posedge k_clk) begin
    s1      <= k_rst ? RST_FLAG : cmd_rd;
    s1_addr <= r_addr;
  end

  // Array fetch with forwarding from the commit in flight
  assign fv_now = dll_on ? s1 : cmd_rd;
  assign fa     = dll_on ? s1_addr : r_addr;
  assign hit    = w1 && (idx(w_addr) == idx(fa));
  assign fd0    = hit ? merge(mem0[idx(fa)], r_d0, r_be0) : mem0[idx(fa)];
  assign fd1    = hit ? merge(mem1[idx(fa)], r_d1, r_be1) : mem1[idx(fa)];

  // Fetched pair
  always_ff @(posedge k_clk) begin
    f_v  <= k_rst ? RST_FLAG : fv_now;
    f_d0 <= fd0;
    f_d1 <= fd1;
  end

  // Beat launched on the true clock: second beat, or first in bypass mode
  assign bk = dll_on ? f_v : fv_now;

  // True-clock half of the double-rate outputs; pin value is the xor of both halves
  always_ff @(posedge k_clk) begin
    if (k_rst) begin
      q_k  <= '0;
      oe_k <= RST_FLAG;
      ep_k <= RST_FLAG;
      en_k <= RST_FLAG;
    end else begin
      q_k  <= (bk ? (dll_on ? f_d1 : fd0) : '0) ^ q_kn;
      oe_k <= bk ^ oe_kn;
      ep_k <= ~ep_kn;
      en_k <= en_kn;
    end
  end

  // Complement-clock half: first beat with delay loop, second in bypass
  always_ff @(posedge k_clk_n) begin
    if (k_rst) begin
      q_kn  <= '0;
      oe_kn <= RST_FLAG;
      ep_kn <= RST_FLAG;
      en_kn <= RST_FLAG;
    end else begin
      q_kn  <= (f_v ? (dll_on ? f_d0 : f_d1) : '0) ^ q_k;
      oe_kn <= f_v ^ oe_k;
      ep_kn <= ep_k;
      en_kn <= ~en_k;
    end
  end

  // Pins from the two halves
  assign dq_o            = q_k ^ q_kn;
  assign dq_oe           = oe_k ^ oe_kn;
  assign read_valid_flag = oe_k ^ oe_kn;
  assign echo_strobe_pos = ep_k ^ ep_kn;
  assign echo_strobe_neg = en_k ^ en_kn;

  // Link side of the record handshake; a commit while busy is not logged
  always_ff @(posedge k_clk) begin
    ack_s <= {ack_s[0], x_ack};
    if (k_rst) begin
      x_req <= RST_FLAG;
    end else if (w1 && (x_req == ack_s[1])) begin
      x_req <= ~x_req;
      rec   <= {w_addr, r_d0, r_d1, r_be0, r_be1};
    end
  end

  // System side: take the record only when the buffer has room
  always_ff @(posedge clk) begin
    req_s <= {req_s[0], x_req};
    if (srst) begin
      x_ack <= RST_FLAG;
    end else if (f_in_valid && f_in_ready) begin
      x_ack <= ~x_ack;
    end
  end
  assign f_in_valid = req_s[1] != x_ack;

  word_fifo #(
    .WIDTH (REC_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (rec),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // Registered record output
  assign f_out_ready = !wlog_valid || wlog_ready;
  always_ff @(posedge clk) begin
    if (srst) begin
      wlog_valid <= RST_FLAG;
    end else if (f_out_ready) begin
      wlog_valid <= f_out_valid;
    end
    if (f_out_ready && f_out_valid) begin
      {wlog_addr, wlog_data, wlog_lanes} <= f_out_data;
    end
  end

  // Read sequences
  sequence rd_dll_s;
    !r_load_n && r_rw && dll_on;
  endsequence
  sequence launch_s;
    ##2 (f_v && read_valid_flag);
  endsequence

  AST_RD_LAT_DLL: assert property (@(posedge k_clk) disable iff (k_rst)
    rd_dll_s |-> launch_s) else $error("first read beat late with delay loop");
  AST_RD_BEAT2: assert property (@(posedge k_clk_n) disable iff (k_rst)
    rd_dll_s ##1 dll_on [*2] |-> ##1 (dq_oe && dq_o == $past(f_d1))) else $error("second read beat wrong");
  AST_RD_BYPASS: assert property (@(posedge k_clk) disable iff (k_rst)
    (cmd_rd && !dll_on) ##1 !dll_on |-> read_valid_flag) else $error("bypass read latency wrong");
  AST_OE_HIZ: assert property (@(posedge k_clk) disable iff (k_rst)
    dq_oe == f_v) else $error("data pins driven without read");
  AST_VALID_ALIGN: assert property (@(posedge k_clk_n) disable iff (k_rst)
    (dll_on && f_v) |-> ##1 (read_valid_flag && dq_oe)) else $error("read valid not aligned to data");
  AST_ECHO_PHASE: assert property (@(posedge k_clk_n) disable iff (k_rst)
    $past(!k_rst) |-> (echo_strobe_pos && !echo_strobe_neg)) else $error("echo clocks out of phase");
  AST_LATE_WRITE: assert property (@(posedge k_clk) disable iff (k_rst)
    cmd_wr |=> (w1 && w_addr == $past(r_addr))) else $error("write address not buffered");
  AST_NO_ACCESS: assert property (@(posedge k_clk) disable iff (k_rst)
    r_load_n |=> (!w1 && !s1)) else $error("access started without load strobe");
  AST_FORWARD: assert property (@(posedge k_clk) disable iff (k_rst)
    (fv_now && hit) |=> (f_d0 == merge($past(mem0[idx(fa)]), $past(r_d0), $past(r_be0))))
    else $error("read missed pending write");
endmodule
`default_nettype wire

//--- test/link_master.sv
`default_nettype none
// Controller model that drives commands and data on the link
module link_master (
  // Link clocks
  input  wire logic                              k_clk,
  input  wire logic                              k_clk_n,
  // Command and write data pins
  output logic                                   load_strobe_n,
  output logic                                   rw_sel,
  output logic [sram_port_pkg::ADDR_W-1:0]       word_address,
  output logic [sram_port_pkg::LANES-1:0]        lane_write_en_n,
  output logic [sram_port_pkg::DATA_W-1:0]       dq_i,
  // Device answer
  input  wire logic [sram_port_pkg::DATA_W-1:0]  dq_o,
  input  wire logic                              dq_oe,
  input  wire logic                              read_valid_flag,
  input  wire logic                              echo_strobe_pos,
  input  wire logic                              echo_strobe_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  import sram_port_pkg::*;
  logic oe_seen;
  // Pins start deselected
  initial begin
    load_strobe_n = 1'b1;
    rw_sel = 1'b0;
    word_address = '0;
    lane_write_en_n = 4'hF;
    dq_i = 36'h000000000;
    oe_seen = 1'b0;
  end
  // Notes any drive of the data pins, away from the edges
  always @(k_clk) begin
    #7 if (dq_oe !== 1'b0) oe_seen <= 1'b1;
  end
  // Deselected cycles; released pins show the inverse pattern
  task automatic idle(input int n);
    oe_seen = 1'b0;
    repeat (n) begin
      @(posedge k_clk);
      load_strobe_n <= 1'b1;
      rw_sel <= 1'b1;
      dq_i <= ~dq_i;
      lane_write_en_n <= ~lane_write_en_n;
    end
    @(posedge k_clk);
  endtask
  // Write followed at the next edge by a read of the same word, bypass mode
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
                       output logic [DATA_W-1:0] q0, q1);
    load_strobe_n <= 1'b0;
    rw_sel <= 1'b0;
    word_address <= a;
    @(posedge k_clk);
    rw_sel <= 1'b1;
    dq_i <= d0;
    lane_write_en_n <= '0;
    @(posedge k_clk);
    load_strobe_n <= 1'b1;
    dq_i <= d1;
    @(posedge k_clk);
    #7 q0 = dq_o;
    @(posedge k_clk_n);
    #7 q1 = dq_o;
    @(posedge k_clk);
  endtask
  // Late write: beat0 after the command edge, beat1 one cycle on
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
                    input logic [LANES-1:0] l0, l1);
    load_strobe_n <= 1'b0;
    rw_sel <= 1'b0;
    word_address <= a;
    @(posedge k_clk);
    load_strobe_n <= 1'b1;
    dq_i <= d0;
    lane_write_en_n <= ~l0;
    @(posedge k_clk);
    dq_i <= d1;
    lane_write_en_n <= ~l1;
  endtask
  // Read and capture both beats with the qualifying flags
  task automatic rd(input logic [ADDR_W-1:0] a, input logic fast,
                    output logic [DATA_W-1:0] d0, d1, output logic [3:0] f);
    load_strobe_n <= 1'b0;
    rw_sel <= 1'b1;
    word_address <= a;
    @(posedge k_clk);
    load_strobe_n <= 1'b1;
    dq_i <= ~dq_i;
    if (fast) @(posedge k_clk);
    else begin
      repeat (2) @(posedge k_clk);
      @(posedge k_clk_n);
    end
    #7 d0 = dq_o;
    f[3] = (dq_oe === 1'b1) && (read_valid_flag === 1'b1);
    f[1] = (echo_strobe_pos === fast) && (echo_strobe_neg === !fast);
    if (fast) @(posedge k_clk_n);
    else @(posedge k_clk);
    #7 d1 = dq_o;
    f[2] = (dq_oe === 1'b1) && (read_valid_flag === 1'b1);
    f[1] = f[1] && (echo_strobe_pos === !fast) && (echo_strobe_neg === fast);
    if (fast) @(posedge k_clk);
    else @(posedge k_clk_n);
    #7 f[0] = (dq_oe === 1'b0) && (read_valid_flag === 1'b0);
    @(posedge k_clk);
  endtask
endmodule
`default_nettype wire

//--- test/sram_port_tb.sv
`default_nettype none
module sram_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_port_pkg::*;
  // Clocks, reset and controls
  logic                clk, srst, k_clk, k_clk_n, dll_off_n, wlog_ready;
  // Link and record signals
  logic                load_strobe_n, rw_sel, dq_oe, read_valid_flag;
  logic                echo_strobe_pos, echo_strobe_neg, wlog_valid;
  logic [ADDR_W-1:0]   word_address, wlog_addr;
  logic [LANES-1:0]    lane_write_en_n;
  logic [DATA_W-1:0]   dq_i, dq_o, r0, r1;
  logic [2*DATA_W-1:0] wlog_data;
  logic [2*LANES-1:0]  wlog_lanes;
  logic [3:0]          rf;
  int                  error_cnt = 0, tests_run = 0, cyc = 0;
  localparam logic [DATA_W-1:0] ONES = 36'hFFFFFFFFF;

  sram_port sram_port_inst (.clk, .srst, .k_clk, .k_clk_n, .load_strobe_n, .rw_sel,
    .word_address, .lane_write_en_n, .dll_off_n, .dq_i, .dq_o, .dq_oe, .echo_strobe_pos,
    .echo_strobe_neg, .read_valid_flag, .wlog_valid, .wlog_ready, .wlog_addr, .wlog_data,
    .wlog_lanes);
  link_master link_master_inst (.k_clk, .k_clk_n, .load_strobe_n, .rw_sel, .word_address,
    .lane_write_en_n, .dq_i, .dq_o, .dq_oe, .read_valid_flag, .echo_strobe_pos,
    .echo_strobe_neg);

  // System clock and an unrelated link clock pair
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    k_clk = 1'b0;
    #7;
    forever #15 k_clk = ~k_clk;
  end
  assign k_clk_n = ~k_clk;
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [71:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Per-lane merge of new bytes over old ones
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
                                             input logic [LANES-1:0] l);
    merge = o;
    for (int i = 0; i < LANES; i++) begin
      if (l[i]) merge[9*i+:9] = n[9*i+:9];
    end
  endfunction
  function automatic logic [DATA_W-1:0] pat0(input int i);
    pat0 = 36'h0A5A50000 + i;
  endfunction
  function automatic logic [DATA_W-1:0] pat1(input int i);
    pat1 = 36'h05A5A0000 + i;
  endfunction
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic fast,
                        input logic [DATA_W-1:0] e0, e1);
    link_master_inst.rd(a, fast, r0, r1, rf);
    chk("read beat0", e0, r0);
    chk("read beat1", e1, r1);
    chk("read flags", 4'hF, rf);
  endtask
  // Spaced writes with the record sink stalled, then a full drain
  task automatic t_fill();
    logic [ADDR_W-1:0] got[$];
    for (int i = 0; i < 20; i++) begin
      link_master_inst.wr(i, pat0(i), pat1(i), 4'hF, 4'hF);
      link_master_inst.idle(12);
    end
    @(posedge clk);
    wlog_ready <= 1'b1;
    repeat (60) begin
      @(negedge clk);
      if (wlog_valid === 1'b1) begin
        if (got.size() == 0) chk("record data", {pat0(0), pat1(0)}, wlog_data);
        if (got.size() == 0) chk("record lanes", 8'hFF, wlog_lanes);
        got.push_back(wlog_addr);
      end
    end
    @(posedge clk);
    wlog_ready <= 1'b0;
    chk("record count", 1'b1, got.size() inside {17, 18});
    for (int i = 0; i < 17; i++) chk("record order", i, got[i]);
  endtask
  // Lane masks differ between the two beats
  task automatic t_mask();
    link_master_inst.wr(3, ONES, ONES, 4'h5, 4'hA);
    link_master_inst.idle(2);
    rd_chk(3, 1'b0, merge(pat0(3), ONES, 4'h5), merge(pat1(3), ONES, 4'hA));
  endtask
  // Read right behind a write to the same place
  task automatic t_forward();
    link_master_inst.wr(5, 36'h123456789, 36'h0FEDCBA98, 4'hF, 4'hF);
    rd_chk(5, 1'b0, 36'h123456789, 36'h0FEDCBA98);
    link_master_inst.idle(2);
  endtask
  // Bypass latency mode
  task automatic t_bypass();
    @(posedge k_clk);
    dll_off_n <= 1'b0;
    link_master_inst.idle(4);
    rd_chk(5, 1'b1, 36'h123456789, 36'h0FEDCBA98);
    link_master_inst.wr_rd(6, 36'h0C3C3C3C3, 36'h03C3C3C3C, r0, r1);
    chk("forward beat0", 36'h0C3C3C3C3, r0);
    chk("forward beat1", 36'h03C3C3C3C, r1);
    dll_off_n <= 1'b1;
    link_master_inst.idle(4);
  endtask
  // Strobe high with read direction starts nothing
  task automatic t_no_access();
    link_master_inst.idle(8);
    chk("pins driven", 1'b0, link_master_inst.oe_seen);
  endtask
  // Main sequence
  initial begin
    srst = 1'b1;
    dll_off_n = 1'b1;
    wlog_ready = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("reset outputs", 5'h00, {dq_oe, echo_strobe_pos, echo_strobe_neg, read_valid_flag, wlog_valid});
    @(posedge clk);
    srst <= 1'b0;
    @(posedge k_clk);
    link_master_inst.idle(6);
    t_fill();
    rd_chk(7, 1'b0, pat0(7), pat1(7));
    t_mask();
    t_forward();
    t_bypass();
    t_no_access();
    report_and_stop();
  end
endmodule
`default_nettype wire
